// ==== verilog/dpr_pkg.sv ====
// dual-port block memory core: shared constants
// assumes nothing beyond a SystemVerilog compiler
package dpr_pkg;

   // ----------------------------------------
   // array geometry
   // ----------------------------------------
   localparam int DATA_W = 72;
   localparam int DBITS = 64;
   localparam int CHK_W = 8;
   localparam int STRB_W = 9;
   localparam int BYTE_W = 8;
   localparam int LOC_AW = 12;
   localparam int MATCH_W = 11;
   localparam int ADDR_W = 23;
   localparam int LAT_W = 4;
   localparam int CNT_W = 5;
   localparam int DLY_N = 15;

   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_LAT = 4;
   localparam int CTRL_ECC_WR_A = 8;
   localparam int CTRL_ECC_RD_A = 9;
   localparam int CTRL_ECC_WR_B = 10;
   localparam int CTRL_ECC_RD_B = 11;
   localparam int CTRL_EXT_A = 12;
   localparam int CTRL_EXT_B = 13;
   localparam int STAT_ASLEEP = 0;
   localparam int STAT_LAT = 4;

   // ----------------------------------------
   // reset values and limits
   // ----------------------------------------
   localparam logic [LAT_W-1:0] LAT_MIN = 4'h3;
   localparam logic [LAT_W-1:0] LAT_RST = 4'h5;
   localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
   localparam logic [DATA_W-1:0] FLIP_ONE = 72'h00_0000_0000_0000_0001;
   localparam logic [DATA_W-1:0] FLIP_TWO = 72'h00_0000_0000_0000_0003;
   localparam logic [6:0] POS_END = 7'h48;

   // position of a block within a chain
   typedef enum logic [1:0] {
      DPR_CHAIN_NONE = 2'h0,
      DPR_CHAIN_FIRST = 2'h1,
      DPR_CHAIN_MIDDLE = 2'h3,
      DPR_CHAIN_LAST = 2'h2
   } dpr_chain_t;

endpackage

// ==== verilog/dpr_core.sv ====
// dual-port block memory core: per-port pipeline and top with array
// assumes one clock, user fabric on both ports, config over Avalon-MM
// Notes on behaviour
// - auto sleep ignores sleep input, counts idle
// - per port write encoder on or off
// - per port read decoder on or off
// - optional input stage registers all request inputs
// - optional stage after array read output
// - optional stage after decoder data and errors
// - one bit enables both chain stages
// - port reset synchronous or asynchronous per port
// - mask selects ignored upper address bits
// - outside enables gate output stages, unchained only
// - shared clock, each port reads or writes
// - port A first; B reads new data
// - A reads old data when B writes
// - both write: port B data wins
// - one edge read, plus one per stage
// - write one edge; read output holds while awake
// - disabled output stages keep their contents
// - lookahead 3 to 15, early inputs delayed
// - reset clears outputs, beats reads and enables
// - byte strobes ignored on reads
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// ----------------------------------------
// one port: input stage, latch, output stages
// ----------------------------------------
module dpr_port #(
   parameter bit IN_STAGE = 1'b0,
   parameter bit ARR_STAGE = 1'b0,
   parameter bit COR_STAGE = 1'b0,
   parameter bit CHAIN_STAGE = 1'b0,
   parameter bit RST_ASYNC = 1'b0,
   parameter dpr_pkg::dpr_chain_t CHAIN_POS = dpr_pkg::DPR_CHAIN_NONE,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_ADDR = 11'h000,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_MASK = 11'h7FF
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic port_rst_i,
   input wire logic en_i,
   input wire logic read_write_select_i,
   input wire logic [dpr_pkg::STRB_W-1:0] byte_write_strobes_i,
   input wire logic [dpr_pkg::ADDR_W-1:0] addr_i,
   input wire logic [dpr_pkg::DATA_W-1:0] wdata_i,
   input wire logic single_fault_insert_i,
   input wire logic double_fault_insert_i,
   input wire logic ecc_wr_en_i,
   input wire logic ecc_rd_en_i,
   input wire logic ext_ce_sel_i,
   input wire logic array_stage_clock_enable_i,
   input wire logic corrected_stage_clock_enable_i,
   input wire logic asleep_i,
   input wire logic [dpr_pkg::DATA_W-1:0] chain_rdata_i,
   input wire logic chain_valid_i,
   input wire logic [dpr_pkg::DATA_W-1:0] arr_rdata_i,
   output logic acc_en_o,
   output logic acc_wr_o,
   output logic [dpr_pkg::STRB_W-1:0] acc_strb_o,
   output logic [dpr_pkg::LOC_AW-1:0] acc_addr_o,
   output logic [dpr_pkg::DATA_W-1:0] acc_wdata_o,
   output logic [dpr_pkg::DATA_W-1:0] rdata_o,
   output logic read_done_indication_o,
   output logic single_err_o,
   output logic double_err_o
);
   typedef struct packed {
      logic en;
      logic wr;
      logic [dpr_pkg::STRB_W-1:0] strb;
      logic [dpr_pkg::ADDR_W-1:0] addr;
      logic [dpr_pkg::DATA_W-1:0] wd;
      logic sf;
      logic df;
      logic lat_v;
      logic [dpr_pkg::DATA_W-1:0] lat_d;
      logic arr_v;
      logic [dpr_pkg::DATA_W-1:0] arr_d;
      logic cor_v;
      logic cor_s;
      logic cor_db;
      logic [dpr_pkg::DATA_W-1:0] cor_d;
      logic ch_v;
      logic ch_s;
      logic ch_db;
      logic [dpr_pkg::DATA_W-1:0] ch_d;
   } dpr_port_st_t;

   localparam bit CHAINED = (CHAIN_POS != dpr_pkg::DPR_CHAIN_NONE);
   localparam bit FEED = (CHAIN_POS == dpr_pkg::DPR_CHAIN_MIDDLE) ||
      (CHAIN_POS == dpr_pkg::DPR_CHAIN_LAST);
   localparam bit STAGED = IN_STAGE | CHAIN_STAGE;

   // check bits of a 64-bit word, extended Hamming code
   function automatic logic [dpr_pkg::CHK_W-1:0] chk(input logic [dpr_pkg::DBITS-1:0] d);
      logic [dpr_pkg::CHK_W-1:0] c;
      logic [6:0] p;
      logic [6:0] k;
      c = '0;
      k = '0;
      for (p = 7'h01; p < dpr_pkg::POS_END; p++) begin
         if ((p & (p - 7'h01)) != 7'h00) begin
            for (int i = 0; i < 7; i++) begin
               if (p[i]) begin
                  c[i] = c[i] ^ d[k[5:0]];
               end
            end
            k = k + 7'h01;
         end
      end
      c[7] = ^{d, c[6:0]};
      return c;
   endfunction

   // flip the data bit sitting at a syndrome position
   function automatic logic [dpr_pkg::DBITS-1:0] fix(input logic [dpr_pkg::DBITS-1:0] d,
                                                     input logic [6:0] syn);
      logic [dpr_pkg::DBITS-1:0] r;
      logic [6:0] p;
      logic [6:0] k;
      r = d;
      k = '0;
      for (p = 7'h01; p < dpr_pkg::POS_END; p++) begin
         if ((p & (p - 7'h01)) != 7'h00) begin
            if (p == syn) begin
               r[k[5:0]] = ~r[k[5:0]];
            end
            k = k + 7'h01;
         end
      end
      return r;
   endfunction

   dpr_port_st_t q;
   dpr_port_st_t n;
   logic arst;
   logic srst;
   logic en_s;
   logic wr_s;
   logic [dpr_pkg::STRB_W-1:0] strb_s;
   logic [dpr_pkg::ADDR_W-1:0] addr_s;
   logic [dpr_pkg::DATA_W-1:0] wd_s;
   logic sf_s;
   logic df_s;
   logic hit;
   logic rd;
   logic a_v;
   logic [dpr_pkg::DATA_W-1:0] a_d;
   logic [dpr_pkg::CHK_W-1:0] syn;
   logic [dpr_pkg::DATA_W-1:0] dec_d;
   logic dec_s;
   logic dec_db;
   logic c_v;
   logic c_s;
   logic c_db;
   logic [dpr_pkg::DATA_W-1:0] c_d;
   logic ce_arr;
   logic ce_cor;
   logic o_v;
   logic o_s;
   logic o_db;
   logic [dpr_pkg::DATA_W-1:0] o_d;

   // reset style chosen per port
   assign arst = RST_ASYNC & port_rst_i;
   assign srst = rst_i | (~RST_ASYNC & port_rst_i);

   // request path, staged or direct
   always_comb begin
      en_s = STAGED ? q.en : en_i;
      wr_s = STAGED ? q.wr : read_write_select_i;
      strb_s = STAGED ? q.strb : byte_write_strobes_i;
      addr_s = STAGED ? q.addr : addr_i;
      wd_s = STAGED ? q.wd : wdata_i;
      sf_s = IN_STAGE ? q.sf : single_fault_insert_i;
      df_s = IN_STAGE ? q.df : double_fault_insert_i;
      hit = ((addr_s[dpr_pkg::ADDR_W-1:dpr_pkg::LOC_AW] ^ SELF_ADDR) & ~SELF_MASK) == '0;
      acc_en_o = en_s & hit & ~asleep_i;
      acc_wr_o = wr_s;
      acc_addr_o = addr_s[dpr_pkg::LOC_AW-1:0];
      acc_strb_o = wr_s ? (ecc_wr_en_i ? '1 : strb_s) : '0;
      acc_wdata_o = wd_s;
      if (ecc_wr_en_i) begin
         acc_wdata_o = {chk(wd_s[dpr_pkg::DBITS-1:0]), wd_s[dpr_pkg::DBITS-1:0]};
         if (sf_s) begin
            acc_wdata_o = acc_wdata_o ^ dpr_pkg::FLIP_ONE;
         end
         if (df_s) begin
            acc_wdata_o = acc_wdata_o ^ dpr_pkg::FLIP_TWO;
         end
      end
      rd = acc_en_o & ~wr_s;
   end

   // enables of the two output stages
   assign ce_arr = (ext_ce_sel_i & ~CHAINED) ? array_stage_clock_enable_i : q.lat_v;
   assign ce_cor = (ext_ce_sel_i & ~CHAINED) ? corrected_stage_clock_enable_i : a_v;

   // array side and decoder
   always_comb begin
      a_v = ARR_STAGE ? q.arr_v : q.lat_v;
      a_d = ARR_STAGE ? q.arr_d : q.lat_d;
      syn = chk(a_d[dpr_pkg::DBITS-1:0]) ^ a_d[dpr_pkg::DATA_W-1:dpr_pkg::DBITS];
      dec_d = a_d;
      dec_s = 1'b0;
      dec_db = 1'b0;
      if (ecc_rd_en_i && a_v) begin
         dec_s = (^a_d) == 1'b1;
         dec_db = ((^a_d) == 1'b0) && (syn[6:0] != 7'h00);
         if (dec_s) begin
            dec_d[dpr_pkg::DBITS-1:0] = fix(a_d[dpr_pkg::DBITS-1:0], syn[6:0]);
         end
      end
      c_v = COR_STAGE ? q.cor_v : a_v;
      c_s = COR_STAGE ? q.cor_s : dec_s;
      c_db = COR_STAGE ? q.cor_db : dec_db;
      c_d = COR_STAGE ? q.cor_d : dec_d;
   end

   // chain exit: own read or data passed up from below
   always_comb begin
      o_v = c_v | (FEED & chain_valid_i);
      o_d = (FEED && !c_v && chain_valid_i) ? chain_rdata_i : c_d;
      o_s = c_s;
      o_db = c_db;
   end

   // next state of every stage
   always_comb begin
      n = q;
      n.en = en_i;
      n.wr = read_write_select_i;
      n.strb = byte_write_strobes_i;
      n.addr = addr_i;
      n.wd = wdata_i;
      n.sf = single_fault_insert_i;
      n.df = double_fault_insert_i;
      n.lat_v = rd & ~asleep_i;
      if (asleep_i) begin
         n.lat_d = '0;
      end else if (rd) begin
         n.lat_d = arr_rdata_i;
      end
      if (ce_arr) begin
         n.arr_v = q.lat_v;
         n.arr_d = q.lat_d;
      end else begin
         n.arr_v = 1'b0;
      end
      if (ce_cor) begin
         n.cor_v = a_v;
         n.cor_s = dec_s;
         n.cor_db = dec_db;
         n.cor_d = dec_d;
      end else begin
         n.cor_v = 1'b0;
      end
      n.ch_v = o_v;
      if (o_v) begin
         n.ch_s = o_s;
         n.ch_db = o_db;
         n.ch_d = o_d;
      end
   end

   // reset clears every stage before any enable
   always_ff @(posedge sys_clk_i or posedge arst) begin
      if (arst) begin
         q <= '0;
      end else if (srst) begin
         q <= '0;
      end else if (ce_i) begin
         q <= n;
      end
   end

   // outputs, chain stage last in line
   assign rdata_o = CHAIN_STAGE ? q.ch_d : o_d;
   assign read_done_indication_o = CHAIN_STAGE ? q.ch_v : o_v;
   assign single_err_o = CHAIN_STAGE ? q.ch_s : o_s;
   assign double_err_o = CHAIN_STAGE ? q.ch_db : o_db;
endmodule

// ----------------------------------------
// top: config slave, sleep, shared array
// ----------------------------------------
module dpr_core #(
   parameter bit IN_STAGE_A = 1'b0,
   parameter bit ARR_STAGE_A = 1'b0,
   parameter bit COR_STAGE_A = 1'b0,
   parameter bit CHAIN_STAGE_A = 1'b0,
   parameter bit RST_ASYNC_A = 1'b0,
   parameter dpr_pkg::dpr_chain_t CHAIN_POS_A = dpr_pkg::DPR_CHAIN_NONE,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_ADDR_A = 11'h000,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_MASK_A = 11'h7FF,
   parameter bit IN_STAGE_B = 1'b0,
   parameter bit ARR_STAGE_B = 1'b0,
   parameter bit COR_STAGE_B = 1'b0,
   parameter bit CHAIN_STAGE_B = 1'b0,
   parameter bit RST_ASYNC_B = 1'b0,
   parameter dpr_pkg::dpr_chain_t CHAIN_POS_B = dpr_pkg::DPR_CHAIN_NONE,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_ADDR_B = 11'h000,
   parameter logic [dpr_pkg::MATCH_W-1:0] SELF_MASK_B = 11'h7FF
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sleep_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic asleep_o,
   input wire logic [1:0] port_rst_i,
   input wire logic [1:0] en_i,
   input wire logic [1:0] read_write_select_i,
   input wire logic [2*dpr_pkg::STRB_W-1:0] byte_write_strobes_i,
   input wire logic [2*dpr_pkg::ADDR_W-1:0] addr_i,
   input wire logic [2*dpr_pkg::DATA_W-1:0] wdata_i,
   input wire logic [1:0] single_fault_insert_i,
   input wire logic [1:0] double_fault_insert_i,
   input wire logic [1:0] array_stage_clock_enable_i,
   input wire logic [1:0] corrected_stage_clock_enable_i,
   input wire logic [2*dpr_pkg::DATA_W-1:0] chain_rdata_i,
   input wire logic [1:0] chain_valid_i,
   output logic [2*dpr_pkg::DATA_W-1:0] rdata_o,
   output logic [1:0] read_done_indication_o,
   output logic [1:0] single_err_o,
   output logic [1:0] double_err_o
);
   localparam int DW = dpr_pkg::DATA_W;
   localparam int MW = dpr_pkg::MATCH_W;

   typedef struct packed {
      logic auto_sl;
      logic [dpr_pkg::LAT_W-1:0] lat;
      logic [1:0] ecc_wr;
      logic [1:0] ecc_rd;
      logic [1:0] ext;
      logic [dpr_pkg::CNT_W-1:0] idle;
      logic [1:0][dpr_pkg::DLY_N-1:0] dly_en;
      logic [1:0][dpr_pkg::DLY_N-1:0][MW-1:0] dly_hi;
      logic ack;
      logic [31:0] rdata;
   } dpr_top_st_t;

   // merge strobed bytes of a write into a stored word
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] nw,
                                          input logic [dpr_pkg::STRB_W-1:0] s);
      logic [DW-1:0] r;
      r = old;
      for (int b = 0; b < dpr_pkg::STRB_W; b++) begin
         if (s[b]) begin
            r[b*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W] = nw[b*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W];
         end
      end
      return r;
   endfunction

   dpr_top_st_t q;
   dpr_top_st_t n;
   logic [DW-1:0] mem [2**dpr_pkg::LOC_AW];
   logic [31:0] ctrl_img;
   logic [31:0] stat_img;
   logic [31:0] wr_img;
   logic [1:0] en_d;
   logic [1:0][dpr_pkg::ADDR_W-1:0] addr_d;
   logic [1:0] acc_en;
   logic [1:0] acc_wr;
   logic [1:0][dpr_pkg::STRB_W-1:0] acc_strb;
   logic [1:0][dpr_pkg::LOC_AW-1:0] acc_addr;
   logic [1:0][DW-1:0] acc_wd;
   logic [1:0][DW-1:0] arr_rd;
   logic [DW-1:0] a_new;
   logic [DW-1:0] b_base;
   logic [DW-1:0] b_new;
   logic wa;
   logic wb;

   // register images
   always_comb begin
      ctrl_img = '0;
      ctrl_img[dpr_pkg::CTRL_AUTO] = q.auto_sl;
      ctrl_img[dpr_pkg::CTRL_LAT +: dpr_pkg::LAT_W] = q.lat;
      ctrl_img[dpr_pkg::CTRL_ECC_WR_A] = q.ecc_wr[0];
      ctrl_img[dpr_pkg::CTRL_ECC_RD_A] = q.ecc_rd[0];
      ctrl_img[dpr_pkg::CTRL_ECC_WR_B] = q.ecc_wr[1];
      ctrl_img[dpr_pkg::CTRL_ECC_RD_B] = q.ecc_rd[1];
      ctrl_img[dpr_pkg::CTRL_EXT_A] = q.ext[0];
      ctrl_img[dpr_pkg::CTRL_EXT_B] = q.ext[1];
      stat_img = '0;
      stat_img[dpr_pkg::STAT_ASLEEP] = asleep_o;
      stat_img[dpr_pkg::STAT_LAT +: dpr_pkg::LAT_W] = q.lat;
      for (int b = 0; b < 4; b++) begin
         wr_img[b*8 +: 8] = avs_byteenable_i[b] ? avs_writedata_i[b*8 +: 8] : ctrl_img[b*8 +: 8];
      end
   end

   // sleep decision from early enables
   assign asleep_o = q.auto_sl ? (q.idle > {1'b0, q.lat}) : sleep_i;
   assign avs_waitrequest_o = avs_read_i & ~q.ack;
   assign avs_readdata_o = q.rdata;

   // early enable and upper address delayed by the lookahead
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         en_d[p] = q.auto_sl ? q.dly_en[p][q.lat - 4'h1] : en_i[p];
         addr_d[p] = addr_i[p*dpr_pkg::ADDR_W +: dpr_pkg::ADDR_W];
         if (q.auto_sl) begin
            addr_d[p][dpr_pkg::LOC_AW +: MW] = q.dly_hi[p][q.lat - 4'h1];
         end
      end
   end

   // next state: bus slave, counters, delay lines
   always_comb begin
      n = q;
      n.ack = 1'b0;
      if (avs_read_i && !q.ack) begin
         n.ack = 1'b1;
         n.rdata = (avs_address_i == dpr_pkg::REG_CTRL) ? ctrl_img :
            (avs_address_i == dpr_pkg::REG_STAT) ? stat_img : '0;
      end
      if (avs_write_i && avs_address_i == dpr_pkg::REG_CTRL) begin
         n.auto_sl = wr_img[dpr_pkg::CTRL_AUTO];
         n.lat = wr_img[dpr_pkg::CTRL_LAT +: dpr_pkg::LAT_W];
         if (n.lat < dpr_pkg::LAT_MIN) begin
            n.lat = dpr_pkg::LAT_MIN;
         end
         n.ecc_wr = {wr_img[dpr_pkg::CTRL_ECC_WR_B], wr_img[dpr_pkg::CTRL_ECC_WR_A]};
         n.ecc_rd = {wr_img[dpr_pkg::CTRL_ECC_RD_B], wr_img[dpr_pkg::CTRL_ECC_RD_A]};
         n.ext = {wr_img[dpr_pkg::CTRL_EXT_B], wr_img[dpr_pkg::CTRL_EXT_A]};
      end
      if (|en_i) begin
         n.idle = '0;
      end else if (q.idle != dpr_pkg::CNT_MAX) begin
         n.idle = q.idle + 5'h01;
      end
      for (int p = 0; p < 2; p++) begin
         n.dly_en[p] = {q.dly_en[p][dpr_pkg::DLY_N-2:0], en_i[p]};
         n.dly_hi[p] = {q.dly_hi[p][dpr_pkg::DLY_N-2:0],
            addr_i[p*dpr_pkg::ADDR_W+dpr_pkg::LOC_AW +: MW]};
      end
   end

   // control state register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.lat <= dpr_pkg::LAT_RST;
      end else if (ce_i) begin
         q <= n;
      end
   end

   // both port pipelines
   dpr_port #(
      .IN_STAGE(IN_STAGE_A), .ARR_STAGE(ARR_STAGE_A), .COR_STAGE(COR_STAGE_A),
      .CHAIN_STAGE(CHAIN_STAGE_A), .RST_ASYNC(RST_ASYNC_A), .CHAIN_POS(CHAIN_POS_A),
      .SELF_ADDR(SELF_ADDR_A), .SELF_MASK(SELF_MASK_A)
   ) u_port_a (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .port_rst_i(port_rst_i[0]),
      .en_i(en_d[0]), .read_write_select_i(read_write_select_i[0]),
      .byte_write_strobes_i(byte_write_strobes_i[0 +: dpr_pkg::STRB_W]),
      .addr_i(addr_d[0]), .wdata_i(wdata_i[0 +: DW]),
      .single_fault_insert_i(single_fault_insert_i[0]),
      .double_fault_insert_i(double_fault_insert_i[0]),
      .ecc_wr_en_i(q.ecc_wr[0]), .ecc_rd_en_i(q.ecc_rd[0]), .ext_ce_sel_i(q.ext[0]),
      .array_stage_clock_enable_i(array_stage_clock_enable_i[0]),
      .corrected_stage_clock_enable_i(corrected_stage_clock_enable_i[0]),
      .asleep_i(asleep_o), .chain_rdata_i(chain_rdata_i[0 +: DW]),
      .chain_valid_i(chain_valid_i[0]), .arr_rdata_i(arr_rd[0]),
      .acc_en_o(acc_en[0]), .acc_wr_o(acc_wr[0]),
      .acc_strb_o(acc_strb[0]),
      .acc_addr_o(acc_addr[0]), .acc_wdata_o(acc_wd[0]),
      .rdata_o(rdata_o[0 +: DW]), .read_done_indication_o(read_done_indication_o[0]),
      .single_err_o(single_err_o[0]), .double_err_o(double_err_o[0])
   );

   dpr_port #(
      .IN_STAGE(IN_STAGE_B), .ARR_STAGE(ARR_STAGE_B), .COR_STAGE(COR_STAGE_B),
      .CHAIN_STAGE(CHAIN_STAGE_B), .RST_ASYNC(RST_ASYNC_B), .CHAIN_POS(CHAIN_POS_B),
      .SELF_ADDR(SELF_ADDR_B), .SELF_MASK(SELF_MASK_B)
   ) u_port_b (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .port_rst_i(port_rst_i[1]),
      .en_i(en_d[1]), .read_write_select_i(read_write_select_i[1]),
      .byte_write_strobes_i(byte_write_strobes_i[dpr_pkg::STRB_W +: dpr_pkg::STRB_W]),
      .addr_i(addr_d[1]), .wdata_i(wdata_i[DW +: DW]),
      .single_fault_insert_i(single_fault_insert_i[1]),
      .double_fault_insert_i(double_fault_insert_i[1]),
      .ecc_wr_en_i(q.ecc_wr[1]), .ecc_rd_en_i(q.ecc_rd[1]), .ext_ce_sel_i(q.ext[1]),
      .array_stage_clock_enable_i(array_stage_clock_enable_i[1]),
      .corrected_stage_clock_enable_i(corrected_stage_clock_enable_i[1]),
      .asleep_i(asleep_o), .chain_rdata_i(chain_rdata_i[DW +: DW]),
      .chain_valid_i(chain_valid_i[1]), .arr_rdata_i(arr_rd[1]),
      .acc_en_o(acc_en[1]), .acc_wr_o(acc_wr[1]),
      .acc_strb_o(acc_strb[1]),
      .acc_addr_o(acc_addr[1]), .acc_wdata_o(acc_wd[1]),
      .rdata_o(rdata_o[DW +: DW]), .read_done_indication_o(read_done_indication_o[1]),
      .single_err_o(single_err_o[1]), .double_err_o(double_err_o[1])
   );

   // port A acts first, port B sees its result
   always_comb begin
      wa = acc_en[0] & acc_wr[0];
      wb = acc_en[1] & acc_wr[1];
      a_new = merge(mem[acc_addr[0]], acc_wd[0], acc_strb[0]);
      b_base = (wa && acc_addr[0] == acc_addr[1]) ? a_new : mem[acc_addr[1]];
      b_new = merge(b_base, acc_wd[1], acc_strb[1]);
      arr_rd = {b_base, mem[acc_addr[0]]};
   end

   // array writes, port B last so it wins
   always_ff @(posedge sys_clk_i) begin
      if (ce_i) begin
         if (wa) begin
            mem[acc_addr[0]] <= a_new;
         end
         if (wb) begin
            mem[acc_addr[1]] <= b_new;
         end
      end
   end
endmodule

// ==== dv/dpr_core_properties.sv ====
// checker for dpr_core: read flag, hold, reset and freeze timing
// assumes default stages, sync port reset and auto sleep off
`timescale 1ns/1ps
module dpr_core_properties (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic asleep_o,
   input wire logic [1:0] port_rst_i,
   input wire logic [1:0] en_i,
   input wire logic [1:0] read_write_select_i,
   input wire logic [143:0] rdata_o,
   input wire logic [1:0] read_done_indication_o
);
   // reads that a port takes at this edge
   wire logic [1:0] rd = {2{ce_i & ~asleep_o}} & en_i & ~read_write_select_i & ~port_rst_i;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   AST_RD_A: assert property (rd[0] |=> read_done_indication_o[0])
      else $error("port a read not flagged");
   AST_RD_B: assert property (rd[1] |=> read_done_indication_o[1])
      else $error("port b read not flagged");
   AST_WR_A: assert property (ce_i && !rd[0] && !port_rst_i[0] |=> !read_done_indication_o[0])
      else $error("port a flagged without read");
   AST_SRC_B: assert property (read_done_indication_o[1] |->
      $past(rd[1]) || !$past(ce_i) && $past(read_done_indication_o[1]))
      else $error("port b flag without cause");
   AST_HOLD_A: assert property (!read_done_indication_o[0] && !$past(rst_i) &&
      !$past(port_rst_i[0]) |-> $stable(rdata_o[71:0])) else $error("port a data moved");
   AST_HOLD_B: assert property (!read_done_indication_o[1] && !$past(rst_i) &&
      !$past(port_rst_i[1]) |-> $stable(rdata_o[143:72])) else $error("port b data moved");
   AST_RST_A: assert property (port_rst_i[0] |=> rdata_o[71:0] == 72'h0 &&
      !read_done_indication_o[0]) else $error("port a reset not cleared");
   AST_FRZ_A: assert property (!ce_i && !port_rst_i[0] |=> $stable(rdata_o[71:0]) &&
      $stable(read_done_indication_o[0])) else $error("port a stage not frozen");
endmodule
bind dpr_core dpr_core_properties dpr_core_properties_inst (.sys_clk_i, .rst_i, .ce_i,
   .asleep_o, .port_rst_i, .en_i, .read_write_select_i, .rdata_o, .read_done_indication_o);

// ==== dv/dpr_fabric.sv ====
// user fabric model: fills array words 0 to 3, then random traffic on both ports
// assumes mode 0 idle, 1 fill, 2 random; default match mask
`timescale 1ns/1ps
module dpr_fabric (
   input wire logic sys_clk_i,
   input wire logic [1:0] mode_i,
   output logic [1:0] en_o = 2'h0,
   output logic [1:0] rw_o = 2'h0,
   output logic [17:0] strb_o = 18'h0,
   output logic [45:0] addr_o = 46'h0,
   output logic [143:0] wdata_o = 144'h0,
   output logic [1:0] sfi_o = 2'h0,
   output logic [1:0] dfi_o = 2'h0,
   output logic [1:0] ace_o = 2'h0,
   output logic [1:0] cce_o = 2'h0
);
   logic [1:0] k = 2'h0;
   // new request each edge; upper address bits random, masked off
   always @(posedge sys_clk_i) begin
      k <= k + 2'h1;
      en_o <= mode_i[1] ? 2'($urandom) : {2{mode_i[0]}};
      rw_o <= mode_i[1] ? 2'($urandom) : 2'h3;
      strb_o <= mode_i[1] ? 18'($urandom) : 18'h3FFFF;
      addr_o <= {11'($urandom), 10'h0, mode_i[1] ? 2'($urandom) : k ^ 2'h1,
         11'($urandom), 10'h0, mode_i[1] ? 2'($urandom) : k};
      wdata_o <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      sfi_o <= 2'($urandom);
      dfi_o <= 2'($urandom);
      ace_o <= 2'($urandom);
      cce_o <= 2'($urandom);
   end
endmodule

// ==== dv/test_dpr_core.sv ====
// testbench for dpr_core: config registers, then random dual-port traffic
// assumes the fabric model on the ports and an Avalon-MM master here
`timescale 1ns/1ps
module test_dpr_core;
   logic sys_clk_i = 0, rst_i = 1, ce_i = 1, sleep_i = 0, avs_read_i = 0, avs_write_i = 0;
   logic [3:0] avs_address_i = 0, avs_byteenable_i = 0;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
   logic avs_waitrequest_o, asleep_o;
   logic [1:0] port_rst_i = 0, chain_valid_i = 0, mode = 0, en, rw, sfi, dfi, ace, cce, rdn, se, de;
   logic [1:0] xr = 0, a;
   logic [17:0] strb;
   logic [45:0] addr;
   logic [143:0] wdata, rdata_o, chain_rdata_i = 0;
   logic [71:0] mem [4];
   logic [71:0] xd [2] = '{72'h0, 72'h0};
   int error_cnt = 0, n_compared = 0;
   // write, address, write data, expected read data
   logic [68:0] tbl [6] = '{{1'b0, 4'h0, 32'h0, 32'h50}, {1'b1, 4'h0, 32'h20, 32'h0},
      {1'b0, 4'h4, 32'h0, 32'h30}, {1'b1, 4'h0, 32'hF0, 32'h0}, {1'b0, 4'h4, 32'h0, 32'hF0},
      {1'b0, 4'h8, 32'h0, 32'h0}};
   always #4 sys_clk_i = ~sys_clk_i;
   dpr_fabric dpr_fabric_inst (.sys_clk_i, .mode_i(mode), .en_o(en), .rw_o(rw), .strb_o(strb),
      .addr_o(addr), .wdata_o(wdata), .sfi_o(sfi), .dfi_o(dfi), .ace_o(ace), .cce_o(cce));
   dpr_core dpr_core_inst (.sys_clk_i, .rst_i, .ce_i, .sleep_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .asleep_o, .port_rst_i, .en_i(en), .read_write_select_i(rw), .byte_write_strobes_i(strb),
      .addr_i(addr), .wdata_i(wdata), .single_fault_insert_i(sfi), .double_fault_insert_i(dfi),
      .array_stage_clock_enable_i(ace), .corrected_stage_clock_enable_i(cce), .chain_rdata_i,
      .chain_valid_i, .rdata_o, .read_done_indication_o(rdn), .single_err_o(se),
      .double_err_o(de));
   // strobe merge of a written word
   function automatic logic [71:0] mrg(logic [71:0] o, logic [71:0] n, logic [8:0] s);
      for (int k = 0; k < 9; k++) if (s[k]) o[k*8 +: 8] = n[k*8 +: 8];
      return o;
   endfunction
   task chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one register access, held until waitrequest is seen low
   task bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge sys_clk_i);
      {avs_write_i, avs_read_i, avs_address_i, avs_writedata_i} <= {w, !w, ad, d};
      avs_byteenable_i <= {3'($urandom), 1'b1};
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) error_cnt++;
      if (n >= 50) results();
      r = avs_readdata_o;
      {avs_write_i, avs_read_i} <= 2'h0;
   endtask
   initial begin
      void'($urandom(11));
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 0;
      // reset value, lookahead floor and ceiling, unmapped address
      foreach (tbl[i]) begin
         bus(tbl[i][68], tbl[i][67:64], tbl[i][63:32], q);
         if (!tbl[i][68]) chk("register", 72'(q), 72'(tbl[i][31:0]));
      end
      // fill, random traffic with clock enable gaps, then port reset over a low enable
      for (int i = 0; i < 320; i++) begin
         @(posedge sys_clk_i);
         mode <= i < 4 ? 2'h1 : i < 300 ? 2'h2 : 2'h0;
         ce_i <= i > 3 && i < 300 ? ($urandom & 32'h7) != 32'h0 : i != 310;
         port_rst_i <= i == 310 ? 2'h3 : 2'h0;
         @(negedge sys_clk_i);
         chk("rdata_a", rdata_o[71:0], xd[0]);
         chk("rdata_b", rdata_o[143:72], xd[1]);
         chk("read_done", 72'(rdn), 72'(xr));
         chk("errors", 72'({se, de}), 72'h0);
         for (int p = 0; p < 2; p++) begin
            a = addr[p*23 +: 2];
            if (port_rst_i[p]) {xr[p], xd[p]} = 73'h0;
            else if (ce_i) begin
               xr[p] = en[p] & !rw[p];
               if (xr[p]) xd[p] = mem[a];
               if (en[p] & rw[p]) mem[a] = mrg(mem[a], wdata[p*72 +: 72], strb[p*9 +: 9]);
            end
         end
      end
      results();
   end
endmodule
